// *** core/bsou_operand_unit.sv ***
// Purpose: Second operand generator with barrel shifter, carry out and
//          write-back steering for data processing instructions.
// Assumes: Register file supplies operand and shift-amount values the same
//          cycle; ALU result and flags come back from the ALU.
// Notes:   One pipeline register on every output.
`timescale 1ns/1ps
module bsou_operand_unit
  import bsou_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_instruction,
  input  wire logic [31:0] i_instr_address,
  input  wire logic [31:0] i_shifted_operand_register,
  input  wire logic [31:0] i_shift_amount_register,
  input  wire logic [31:0] i_current_status_word,
  input  wire logic [31:0] i_saved_status_word,
  input  wire logic        i_logical_class,
  input  wire logic [31:0] i_alu_result,
  input  wire logic        i_alu_carry,
  output logic      [31:0] o_operand2,
  output logic             o_shifter_carry,
  output logic             o_valid,
  output logic             o_undefined,
  output logic             o_write_reg,
  output logic             o_write_pc,
  output logic             o_restore_status,
  output logic             o_update_flags,
  output logic             o_carry_flag,
  output logic      [2:0]  o_fetch_cycles,
  output logic             o_internal_cycle
);

  // Rotate a 32-bit value right by 0..31 into a 33-bit lane, used for the rotated immediate and ROR
  function automatic logic [32:0] bsou_rotr33(input logic [31:0] value, input logic [4:0] amt);
    logic [63:0] twice;
    twice = {value, value} >> amt;
    bsou_rotr33 = {1'b0, twice[31:0]};
  endfunction : bsou_rotr33

  logic [31:0] operand2_reg;
  logic        carry_reg;
  logic        valid_reg;
  logic        undefined_reg;
  logic        write_reg_reg;
  logic        write_pc_reg;
  logic        restore_reg;
  logic        update_reg;
  logic        carry_flag_reg;
  logic [2:0]  fetch_reg;
  logic        internal_reg;

  // Field decode
  wire logic        imm_form   = i_instruction[IMM_FLAG_BIT];
  wire logic        reg_shift  = ~imm_form & i_instruction[REG_SHIFT_BIT];
  wire logic        set_flags  = i_instruction[SET_FLAGS_BIT];
  wire logic [3:0]  opcode     = i_instruction[OPCODE_LSB +: 4];
  wire logic [3:0]  rd_index   = i_instruction[RD_LSB +: 4];
  wire logic [3:0]  rm_index   = i_instruction[3:0];
  wire logic [1:0]  shift_type = i_instruction[SHIFT_TYPE_LSB +: 2];
  wire logic [4:0]  imm_amt    = i_instruction[SHIFT_IMM_LSB +: 5];
  wire logic [7:0]  reg_amt    = i_shift_amount_register[7:0];
  wire logic        old_c      = i_current_status_word[STATUS_C_BIT];
  wire logic        user_mode  = (i_current_status_word[4:0] == USER_MODE);

  // Multiply space: register shift form with bit 7 set is not data processing
  wire logic undefined = reg_shift & i_instruction[MUST_ZERO_BIT];

  // Program counter as operand carries the prefetch offset
  wire logic [31:0] pc_value = i_instr_address + (reg_shift ? PC_OFS_REG : PC_OFS_IMM);
  wire logic [31:0] rm_val   = (rm_index == PC_INDEX) ? pc_value : i_shifted_operand_register;

  // Rotated immediate
  wire logic [4:0]  rot2     = {i_instruction[ROT_LSB +: 4], 1'b0};
  wire logic [32:0] imm_rot  = bsou_rotr33({24'h000000, i_instruction[7:0]}, rot2);

  // Effective amount: immediate zero means 32 for right shifts
  wire logic        amt_zero  = reg_shift ? (reg_amt == 8'h00) : (imm_amt == 5'h00);
  wire logic [4:0]  amt_low   = reg_shift ? reg_amt[4:0] : imm_amt;
  wire logic        amt_is32  = reg_shift ? (reg_amt == 8'h20) : amt_zero;
  wire logic        amt_gt32  = reg_shift & (reg_amt > 8'h20);
  wire logic        amt_ge32  = amt_is32 | amt_gt32;

  // Basic shifter lanes, valid for amounts 1..31
  wire logic [63:0] lsl_wide  = {32'h00000000, rm_val} << amt_low;
  wire logic [32:0] lsr_wide  = {rm_val, 1'b0} >> amt_low;
  wire logic [32:0] asr_wide  = 33'($signed({rm_val, 1'b0}) >>> amt_low);
  wire logic [32:0] ror_lane  = bsou_rotr33(rm_val, amt_low);
  wire logic        ror_carry = rm_val[amt_low - 5'h01];
  wire logic        rrx_sel   = ~imm_form & ~reg_shift & amt_zero & (shift_type == BSOU_ROR_T);

  logic [31:0] shift_result;
  logic        shift_carry;
  always_comb begin
    shift_result = rm_val;
    shift_carry  = old_c;
    if (imm_form) begin
      shift_result = imm_rot[31:0];
      shift_carry  = (rot2 == 5'h00) ? old_c : imm_rot[31];
    end else if (rrx_sel) begin
      shift_result = {old_c, rm_val[31:1]};
      shift_carry  = rm_val[0];
    end else if (amt_zero && (reg_shift || shift_type == BSOU_LSL_T)) begin
      shift_result = rm_val;
      shift_carry  = old_c;
    end else begin
      case (shift_type)
        BSOU_LSL_T: begin
          if (amt_ge32) begin
            shift_result = WORD_RESET;
            shift_carry  = amt_is32 & rm_val[0];
          end else begin
            shift_result = lsl_wide[31:0];
            shift_carry  = lsl_wide[32];
          end
        end
        BSOU_LSR_T: begin
          if (amt_ge32) begin
            shift_result = WORD_RESET;
            shift_carry  = amt_is32 & rm_val[31];
          end else begin
            shift_result = lsr_wide[32:1];
            shift_carry  = lsr_wide[0];
          end
        end
        BSOU_ASR_T: begin
          if (amt_ge32) begin
            shift_result = {DATA_W{rm_val[31]}};
            shift_carry  = rm_val[31];
          end else begin
            shift_result = asr_wide[32:1];
            shift_carry  = asr_wide[0];
          end
        end
        default: begin
          if (amt_low == 5'h00) begin
            shift_result = rm_val;
            shift_carry  = rm_val[31];
          end else begin
            shift_result = ror_lane[31:0];
            shift_carry  = ror_carry;
          end
        end
      endcase
    end
  end

  // Write-back steering
  wire logic test_op   = opcode[3:2] == 2'b10;
  wire logic rd_is_pc  = rd_index == PC_INDEX;
  wire logic legacy    = test_op & rd_is_pc & set_flags;
  wire logic write_pc  = ~test_op & rd_is_pc;
  wire logic restore   = (write_pc & set_flags) | (legacy & ~user_mode);
  wire logic update    = set_flags & ~rd_is_pc;
  wire logic carry_new = i_logical_class ? shift_carry : i_alu_carry;
  wire logic [2:0] fetches = write_pc ? FETCH_PC_WRITE : FETCH_PLAIN;
  wire logic go = i_valid & ~undefined;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      operand2_reg   <= WORD_RESET;
      carry_reg      <= 1'b0;
      valid_reg      <= 1'b0;
      undefined_reg  <= 1'b0;
      write_reg_reg  <= 1'b0;
      write_pc_reg   <= 1'b0;
      restore_reg    <= 1'b0;
      update_reg     <= 1'b0;
      carry_flag_reg <= 1'b0;
      fetch_reg      <= 3'h0;
      internal_reg   <= 1'b0;
    end else begin
      operand2_reg   <= shift_result;
      carry_reg      <= shift_carry;
      valid_reg      <= go;
      undefined_reg  <= i_valid & undefined;
      write_reg_reg  <= go & ~test_op & ~rd_is_pc;
      write_pc_reg   <= go & write_pc;
      restore_reg    <= go & restore;
      update_reg     <= go & update;
      carry_flag_reg <= (go & update) ? carry_new : old_c;
      fetch_reg      <= go ? fetches : 3'h0;
      internal_reg   <= go & reg_shift;
    end
  end

  assign o_operand2       = operand2_reg;
  assign o_shifter_carry  = carry_reg;
  assign o_valid          = valid_reg;
  assign o_undefined      = undefined_reg;
  assign o_write_reg      = write_reg_reg;
  assign o_write_pc       = write_pc_reg;
  assign o_restore_status = restore_reg;
  assign o_update_flags   = update_reg;
  assign o_carry_flag     = carry_flag_reg;
  assign o_fetch_cycles   = fetch_reg;
  assign o_internal_cycle = internal_reg;

  // Checks
  sequence s_issue_lsl0;
    i_valid && !imm_form && !reg_shift && imm_amt == 5'h00 && shift_type == BSOU_LSL_T;
  endsequence
  sequence s_issue_reg_lsr32;
    i_valid && reg_shift && !undefined && shift_type == BSOU_LSR_T && reg_amt == 8'h20;
  endsequence
  // Immediate shift of one type with a non-zero amount field
  sequence s_imm_shift(logic [1:0] kind);
    i_valid && !imm_form && !reg_shift && imm_amt != 5'h00 && shift_type == kind;
  endsequence

  lsl_zero_pass_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_issue_lsl0 |=> (o_operand2 == $past(rm_val) && o_shifter_carry == $past(old_c)))
    else $error("lsl zero altered operand or carry");
  reg_lsr32_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_issue_reg_lsr32 |=> (o_operand2 == 32'h0 && o_shifter_carry == $past(rm_val[31])))
    else $error("register lsr by 32 wrong");
  imm_lsr32_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!imm_form && !reg_shift && imm_amt == 5'h00 && shift_type == BSOU_LSR_T)
      |=> (o_operand2 == 32'h0 && o_shifter_carry == $past(rm_val[31])))
    else $error("immediate lsr 32 wrong");
  rrx_carry_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    rrx_sel |=> (o_shifter_carry == $past(rm_val[0]) && o_operand2[31] == $past(old_c)))
    else $error("rotate through carry wrong");
  asr_fill_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!imm_form && reg_shift && shift_type == BSOU_ASR_T && reg_amt >= 8'h20)
      |=> (o_operand2 == {32{$past(rm_val[31])}}))
    else $error("arithmetic fill wrong");
  undef_block_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && undefined) |=> (o_undefined && !o_valid && !o_write_pc))
    else $error("undefined form was executed");
  pc_fetch_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && write_pc) |=> (o_fetch_cycles == 3'h3 && o_write_pc))
    else $error("pc write fetch count wrong");
  test_nowrite_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && test_op && !rd_is_pc) |=> (!o_write_reg && !o_write_pc))
    else $error("test opcode wrote a register");
  pc_offset_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (rm_index == PC_INDEX && reg_shift) |-> (rm_val == i_instr_address + 32'hc))
    else $error("pc operand offset wrong");

  lsl_fill_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_imm_shift(BSOU_LSL_T) |=> (o_operand2 == ($past(rm_val) << $past(imm_amt))
      && o_shifter_carry == $past(rm_val[5'h00 - imm_amt])))
    else $error("left shift result or carry wrong");

  reg_lsr_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && reg_shift && !undefined && shift_type == BSOU_LSR_T && reg_amt != 8'h00
      && reg_amt < 8'h20) |=> (o_operand2 == ($past(rm_val) >> $past(reg_amt[4:0]))
      && o_shifter_carry == $past(rm_val[reg_amt[4:0] - 5'h01])))
    else $error("register right shift wrong");

  asr_sign_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_imm_shift(BSOU_ASR_T) |=> (o_operand2 == 32'($signed($past(rm_val)) >>> $past(imm_amt))))
    else $error("arithmetic shift sign fill wrong");

  imm_asr32_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && !imm_form && !reg_shift && imm_amt == 5'h00 && shift_type == BSOU_ASR_T)
      |=> (o_operand2 == {32{$past(rm_val[31])}} && o_shifter_carry == $past(rm_val[31])))
    else $error("immediate arithmetic shift 32 wrong");

  ror_wrap_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s_imm_shift(BSOU_ROR_T) |=> (o_operand2 == 32'({$past(rm_val), $past(rm_val)} >> $past(imm_amt))
      && o_shifter_carry == $past(rm_val[imm_amt - 5'h01])))
    else $error("rotate right wrong");

  reg_zero_pass_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && reg_shift && !undefined && reg_amt == 8'h00)
      |=> (o_operand2 == $past(rm_val) && o_shifter_carry == $past(old_c)))
    else $error("register zero amount altered operand");

  reg_lsl32_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && reg_shift && shift_type == BSOU_LSL_T && reg_amt == 8'h20)
      |=> (o_operand2 == 32'h0 && o_shifter_carry == $past(rm_val[0])))
    else $error("register left shift by 32 wrong");

  reg_over32_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && reg_shift && !shift_type[1] && reg_amt > 8'h20)
      |=> (o_operand2 == 32'h0 && !o_shifter_carry))
    else $error("logical shift above 32 not cleared");

  reg_ror32_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && reg_shift && shift_type == BSOU_ROR_T && reg_amt[4:0] == 5'h00
      && reg_amt != 8'h00) |=> (o_operand2 == $past(rm_val) && o_shifter_carry == $past(rm_val[31])))
    else $error("register rotate by 32 wrong");

  imm_rot_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && imm_form) |=> (o_operand2 ==
      32'({2{24'h000000, $past(i_instruction[7:0])}} >> {$past(i_instruction[11:8]), 1'b0})))
    else $error("rotated immediate wrong");

  pc_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && write_pc && !set_flags) |=> (o_write_pc && !o_restore_status && !o_update_flags))
    else $error("pc write touched status");

  pc_restore_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && write_pc && set_flags) |=> (o_write_pc && o_restore_status))
    else $error("pc write did not restore status");

  pc_imm_ofs_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (rm_index == PC_INDEX && !reg_shift) |-> (rm_val == i_instr_address + 32'h8))
    else $error("pc operand immediate offset wrong");

  legacy_user_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && legacy && user_mode) |=> (!o_restore_status && !o_write_pc))
    else $error("legacy test acted in user mode");

  legacy_priv_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && legacy && !user_mode) |=> o_restore_status)
    else $error("legacy test did not restore status");

  plain_fetch_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && !write_pc) |=> (o_fetch_cycles == 3'h1))
    else $error("plain fetch count wrong");

  reg_internal_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (go && reg_shift) |=> o_internal_cycle)
    else $error("internal cycle missing");

  carry_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_valid && !imm_form && !reg_shift && imm_amt == 5'h00 && shift_type == BSOU_LSL_T
      && set_flags && !rd_is_pc && i_logical_class) |=> (o_carry_flag == $past(old_c)))
    else $error("carry not preserved on zero left shift");

  idle_quiet_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!i_valid) |=> (o_fetch_cycles == 3'h0 && !o_valid && !o_write_reg))
    else $error("idle cycle produced activity");

endmodule : bsou_operand_unit

// *** include/bsou_pkg.sv ***
// Purpose: Shared constants for the barrel shifter operand unit.
// Assumes: 32-bit data processing instruction word.
// Notes:   Field positions follow the data processing encoding.
package bsou_pkg;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned IMM_FLAG_BIT    = 25;
  localparam int unsigned OPCODE_LSB      = 21;
  localparam int unsigned SET_FLAGS_BIT   = 20;
  localparam int unsigned RN_LSB          = 16;
  localparam int unsigned RD_LSB          = 12;
  localparam int unsigned SHIFT_IMM_LSB   = 7;
  localparam int unsigned SHIFT_TYPE_LSB  = 5;
  localparam int unsigned REG_SHIFT_BIT   = 4;
  localparam int unsigned MUST_ZERO_BIT   = 7;
  localparam int unsigned RS_LSB          = 8;
  localparam int unsigned ROT_LSB         = 8;
  localparam int unsigned STATUS_C_BIT    = 29;
  localparam logic [3:0]  PC_INDEX        = 4'hf;
  localparam logic [31:0] PC_OFS_IMM      = 32'h0000_0008;
  localparam logic [31:0] PC_OFS_REG      = 32'h0000_000c;
  localparam logic [4:0]  USER_MODE       = 5'h10;
  localparam logic [2:0]  FETCH_PLAIN     = 3'h1;
  localparam logic [2:0]  FETCH_PC_WRITE  = 3'h3;
  localparam logic [8:0]  RESULT_RESET    = 9'h000;
  localparam logic [31:0] WORD_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {
    BSOU_LSL_T = 2'h0,
    BSOU_LSR_T = 2'h1,
    BSOU_ASR_T = 2'h2,
    BSOU_ROR_T = 2'h3
  } bsou_shift_t;

  typedef enum logic [3:0] {
    BSOU_OP_TEST_BITS  = 4'h8,
    BSOU_OP_TEST_EQUIV = 4'h9,
    BSOU_OP_COMPARE    = 4'ha,
    BSOU_OP_COMPARE_N  = 4'hb
  } bsou_opcode_t;
endpackage : bsou_pkg

// *** testbench/bsou_regfile_model.sv ***
// Purpose: Register file and ALU carry stand-in facing the operand unit.
// Assumes: Writes land on the rising edge; reads are combinational.
// Notes:   Slot 15 is never a real register on o_rm_value and o_rs_value and shows a changing pattern there.
`timescale 1ns/1ps
module bsou_regfile_model (
  input  wire logic        i_clock,
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_wr_idx,
  input  wire logic [31:0] i_wr_data,
  input  wire logic [31:0] i_instruction,
  output logic      [31:0] o_rm_value,
  output logic      [31:0] o_rs_value,
  output logic             o_alu_carry
);
  logic [31:0] regs [16];
  logic [31:0] junk_reg;
  initial begin
    junk_reg = 32'h0000_0000;
    for (int i = 0; i < 16; i++) regs[i] = 32'h0000_0000;
  end
  // The unit must substitute the PC itself, so slot 15 never holds still
  always @(posedge i_clock) begin
    junk_reg <= ~junk_reg ^ 32'h5a5a_0f0f;
    if (i_wr_en) regs[i_wr_idx] <= i_wr_data;
  end
  assign o_rm_value  = (i_instruction[3:0] == 4'hf) ? junk_reg : regs[i_instruction[3:0]];
  assign o_rs_value  = (i_instruction[11:8] == 4'hf) ? ~junk_reg : regs[i_instruction[11:8]];
  assign o_alu_carry = regs[i_instruction[19:16]][0];
endmodule : bsou_regfile_model

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the operand unit with a register file model.
// Assumes: Outputs appear on the sampling edge and are read at the next falling edge.
// Notes:   Inputs change on the falling edge; results are checked a cycle later.
`timescale 1ns/1ps
module testbench;
  import bsou_pkg::*;
  logic        i_clock, i_sys_rst, i_valid, i_logical_class, wr_en, i_alu_carry;
  logic [3:0]  wr_idx;
  logic [31:0] i_instruction, i_instr_address, i_cur, i_saved, wr_data, rm_v, rs_v;
  logic [31:0] o_operand2;
  logic [2:0]  o_fetch_cycles;
  logic        o_shifter_carry, o_valid, o_undefined, o_write_reg, o_write_pc;
  logic        o_restore_status, o_update_flags, o_carry_flag, o_internal_cycle;
  logic [31:0] shadow [16];
  logic [31:0] e_op;
  logic [2:0]  e_fetch;
  logic        e_c, e_und, e_wreg, e_wpc, e_rest, e_int, e_cf, e_live, e_cfchk, e_tst, e_upd;
  int          n_errors, n_compared, seed_dummy;
  bsou_operand_unit dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_valid(i_valid),
    .i_instruction(i_instruction), .i_instr_address(i_instr_address),
    .i_shifted_operand_register(rm_v), .i_shift_amount_register(rs_v),
    .i_current_status_word(i_cur), .i_saved_status_word(i_saved),
    .i_logical_class(i_logical_class), .i_alu_result(wr_data), .i_alu_carry(i_alu_carry),
    .o_operand2(o_operand2), .o_shifter_carry(o_shifter_carry), .o_valid(o_valid),
    .o_undefined(o_undefined), .o_write_reg(o_write_reg), .o_write_pc(o_write_pc),
    .o_restore_status(o_restore_status), .o_update_flags(o_update_flags),
    .o_carry_flag(o_carry_flag), .o_fetch_cycles(o_fetch_cycles),
    .o_internal_cycle(o_internal_cycle));
  bsou_regfile_model partner (.i_clock(i_clock), .i_wr_en(wr_en), .i_wr_idx(wr_idx),
    .i_wr_data(wr_data), .i_instruction(i_instruction), .o_rm_value(rm_v),
    .o_rs_value(rs_v), .o_alu_carry(i_alu_carry));

  // Returns {carry, operand}
  function automatic logic [32:0] shift_ref(logic [31:0] ins, logic [31:0] rm,
                                            logic [31:0] rs, logic c);
    logic [7:0]  amt;
    logic [4:0]  r;
    logic [63:0] w;
    w = 64'h0;
    if (ins[IMM_FLAG_BIT]) begin
      r = {ins[11:8], 1'b0};
      w = {24'h0, ins[7:0], 24'h0, ins[7:0]} >> r;
      return {(r == 5'h0) ? c : w[31], w[31:0]};
    end
    amt = ins[REG_SHIFT_BIT] ? rs[7:0] : {3'h0, ins[11:7]};
    if (!ins[REG_SHIFT_BIT] && amt == 8'h0 && ins[6:5] != 2'h0) begin
      if (ins[6:5] == 2'h3) return {rm[0], c, rm[31:1]};
      amt = 8'h20;
    end
    if (amt == 8'h0) return {c, rm};
    case (ins[6:5])
      2'h0: w[32:0] = {1'b0, rm} << amt;
      2'h1: w[32:0] = {rm, 1'b0} >> amt;
      2'h2: w[32:0] = $signed({rm, 1'b0}) >>> ((amt > 8'h20) ? 8'h20 : amt);
      default: begin
        r = amt[4:0];
        if (r == 5'h0) return {rm[31], rm};
        w = {rm, rm} >> r;
        return {rm[r - 5'h1], w[31:0]};
      end
    endcase
    return (ins[6:5] == 2'h0) ? w[32:0] : {w[0], w[32:1]};
  endfunction : shift_ref

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR %0t mismatch got %h want %h", $time, got, want);
    end
  endtask : expect_eq

  task automatic step(input logic [31:0] ins, input logic vld, input logic [3:0] idx,
                      input logic [31:0] dat);
    logic [31:0] rm, adr, cur;
    logic [32:0] sc;
    logic        rsh, pcd, s;
    @(negedge i_clock);
    expect_eq(o_valid, e_live && !e_und);
    expect_eq(o_write_reg, e_wreg);
    expect_eq(o_write_pc, e_wpc);
    if (e_live) expect_eq(o_undefined, e_und);
    if (e_live && !e_und) begin
      expect_eq(o_operand2, e_op);
      expect_eq(o_shifter_carry, e_c);
      expect_eq(o_restore_status, e_rest);
      expect_eq(o_fetch_cycles, e_fetch);
      expect_eq(o_internal_cycle, e_int);
      expect_eq(o_update_flags, e_upd);
      if (e_cfchk) expect_eq(o_carry_flag, e_cf);
    end
    adr = $urandom & 32'hffff_fffc;
    cur = $urandom;
    cur[4:0] = USER_MODE | 5'($urandom_range(0, 3));
    rsh = !ins[IMM_FLAG_BIT] && ins[REG_SHIFT_BIT];
    pcd = ins[15:12] == PC_INDEX;
    s = ins[SET_FLAGS_BIT];
    rm = (ins[3:0] == PC_INDEX) ? adr + (rsh ? PC_OFS_REG : PC_OFS_IMM) : shadow[ins[3:0]];
    sc = shift_ref(ins, rm, shadow[ins[11:8]], cur[STATUS_C_BIT]);
    e_op = sc[31:0];
    e_c = sc[32];
    e_live = vld;
    e_und = rsh && ins[MUST_ZERO_BIT];
    e_tst = ins[24:23] == 2'b10;
    e_wreg = vld && !e_und && !e_tst && !pcd;
    e_wpc = vld && !e_und && !e_tst && pcd;
    e_rest = pcd && s && (!e_tst || cur[4:0] != USER_MODE);
    e_fetch = (!e_tst && pcd) ? FETCH_PC_WRITE : FETCH_PLAIN;
    e_int = rsh;
    e_cfchk = !pcd;
    e_upd = s && !pcd;
    i_logical_class = ins[24] ? (ins[23] | !ins[22]) : (ins[23:22] == 2'b00);
    e_cf = !s ? cur[STATUS_C_BIT] : (i_logical_class ? sc[32] : shadow[ins[19:16]][0]);
    i_instruction = ins;
    i_valid = vld;
    i_instr_address = adr;
    i_cur = cur;
    i_saved = $urandom;
    wr_en = 1'b1;
    wr_idx = idx;
    wr_data = dat;
    shadow[idx] = dat;
  endtask : step

  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  initial begin
    #60000;
    n_errors++;
    $display("ERROR %0t run did not finish", $time);
    results();
  end

  initial begin
    logic [7:0]  amts [6];
    logic [31:0] ins;
    amts = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hff};
    n_errors = 0;
    n_compared = 0;
    {i_valid, i_logical_class, wr_en, wr_idx} = '0;
    {i_instruction, i_instr_address, i_cur, i_saved, wr_data} = '0;
    {e_live, e_und, e_wreg, e_wpc, e_tst, e_cfchk} = '0;
    for (int i = 0; i < 16; i++) shadow[i] = 32'h0000_0000;
    i_sys_rst = 1'b1;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'b0;
    seed_dummy = $urandom(16581);
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 6; k++) begin
        step(32'he000_0000, 1'b1, 4'h0, {24'($urandom), amts[k]});
        step({12'he1b, 4'h1, 8'h20, 1'b0, 2'(t), 1'b1, 4'h5}, 1'b1, 4'h5, $urandom);
        step({12'he1b, 4'h1, 4'h3, 5'(amts[k]), 2'(t), 1'b0, 4'h5}, 1'b1, 4'h6, $urandom);
      end
    end
    for (int n = 0; n < 2000; n++) begin
      ins = $urandom;
      ins[31:26] = 6'h38;
      if (ins[24:23] == 2'b10) ins[SET_FLAGS_BIT] = 1'b1;
      if (!ins[IMM_FLAG_BIT] && ins[REG_SHIFT_BIT]) ins[11] = 1'b0;
      step(ins, ($urandom_range(0, 7) != 0), 4'($urandom_range(0, 14)), $urandom);
    end
    step(32'he000_0000, 1'b0, 4'h0, 32'h0000_0000);
    results();
  end
endmodule : testbench
